// ### src/cpd_top.sv
// Purpose: Four-channel playback command decoder with APB access
// Assumes: Commands are bytes written to the command register
// Notes:   Two-byte commands take two writes
// Function
// - Phrase select latches phrase, no output
// - Ten-bit phrase field covers 0 to 1023
// - Channel field 00..11 maps channel 0..3
// - Direct direct_phrase_launch_cmd starts given phrase when ready
// - Start mask plays latched phrase per channel
// - All-zero mask commands are ignored
// - Stop halts masked channels, releases ready, busy
// - Stop accepted regardless of ready line
// - Silence lasts code plus one times 4ms
// - Loop setting never replays silence
// - Loop set repeats phrase until clear, stop
// - Only the running phrase repeats, never a queued one
// - Loop clear accepted regardless, cancels repeat
// - Loop clear drives ready line high when no command is queued
//
// Implementation choices: register access over APB and the address map.
`timescale 1ns/1ns
module cpd_top #(
	parameter int TICK_CYCLES = cpd_pkg::SIL_TICK_CYC
) (
	// Clock and reset
	input  wire logic                        core_clk,
	input  wire logic                        rst_n,
	// APB slave
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [cpd_pkg::ADDR_W-1:0]  paddr,
	input  wire logic [cpd_pkg::DATA_W-1:0]  pwdata,
	output logic      [cpd_pkg::DATA_W-1:0]  prdata,
	output logic                             pready,
	output logic                             pslverr,
	// Channel status lines
	output logic      [cpd_pkg::CH_N-1:0]    command_ready_line,
	output logic      [cpd_pkg::CH_N-1:0]    channel_busy_n,
	// Playback engine
	input  wire logic [cpd_pkg::CH_N-1:0]    direct_phrase_launch_cmd_done,
	output logic      [cpd_pkg::CH_N-1:0]    launch,
	output logic      [cpd_pkg::CH_N-1:0]    halt,
	output cpd_pkg::cpd_phrase_t [cpd_pkg::CH_N-1:0] launch_phrase
);
	import cpd_pkg::*;

	logic            pend_valid;
	logic [7:0]      pend_byte;
	logic            tick;
	cpd_mask_t       ready_v;
	cpd_mask_t       busy_v;
	cpd_mask_t       rep_v;

	// Bus decode
	wire acc       = psel && penable;
	wire setup     = psel && !penable;
	wire hit_cmd   = (paddr == ADDR_CMD);
	wire hit_stat  = (paddr == ADDR_STATUS);
	wire bad_acc   = acc && !(hit_cmd || (hit_stat && !pwrite));
	wire cmd_wr    = acc && pwrite && hit_cmd;
	wire [7:0] wbyte = pwdata[7:0];

	wire [3:0] op_new  = wbyte[7:4];
	wire [3:0] op_pend = pend_byte[7:4];
	wire two_byte  = (op_new == OP_SELECT) || (op_new == OP_DIRECT) || (op_new == OP_SIL);
	wire one_byte  = (op_new == OP_START) || (op_new == OP_STOP) ||
		(op_new == OP_REPSET) || (op_new == OP_REPCLR);
	wire second    = cmd_wr && pend_valid;
	wire first     = cmd_wr && !pend_valid;
	wire ex1       = first && one_byte;

	wire cpd_mask_t chan_hot = cpd_mask_t'(4'h1 << pend_byte[1:0]);
	wire cpd_phrase_t phrase_in = {pend_byte[3:2], wbyte};
	wire cpd_mask_t m_new  = wbyte[3:0];
	wire cpd_mask_t m_pend = pend_byte[3:0];

	wire cpd_mask_t sel_v   = (second && op_pend == OP_SELECT) ? chan_hot & ready_v : '0;
	wire cpd_mask_t dir_v   = (second && op_pend == OP_DIRECT) ? chan_hot & ready_v : '0;
	wire cpd_mask_t sil_v   = (second && op_pend == OP_SIL) ? m_pend & ready_v : '0;
	wire cpd_mask_t start_v = (ex1 && op_new == OP_START) ? m_new & ready_v : '0;
	wire cpd_mask_t rset_v  = (ex1 && op_new == OP_REPSET) ? m_new & ready_v : '0;
	wire cpd_mask_t stop_v  = (ex1 && op_new == OP_STOP) ? m_new : '0;
	wire cpd_mask_t rclr_v  = (ex1 && op_new == OP_REPCLR) ? m_new : '0;

	wire [DATA_W-1:0] status_word = DATA_W'({pend_valid, rep_v, busy_v, ready_v});
	wire [DATA_W-1:0] rd_next = (hit_stat && !pwrite) ? status_word : RDATA_ZERO;

	assign pready             = 1'b1;
	assign pslverr            = bad_acc;
	assign command_ready_line = ready_v;
	assign channel_busy_n     = busy_v;

	// First byte holding and read data
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pend_valid <= 1'b0;
			pend_byte  <= 8'h00;
			prdata     <= RDATA_ZERO;
		end else begin
			if (setup)
				prdata <= rd_next;
			if (second)
				pend_valid <= 1'b0;
			else if (first && two_byte)
				pend_valid <= 1'b1;
			if (first)
				pend_byte <= wbyte;
		end
	end

	cpd_tick #(
		.CYCLES(TICK_CYCLES)
	) u_tick (
		.core_clk(core_clk),
		.rst_n   (rst_n),
		.tick    (tick)
	);

	for (genvar g = 0; g < CH_N; g++) begin : g_ch
		cpd_chan_if u_if ();
		assign u_if.sel        = sel_v[g] || dir_v[g];
		assign u_if.launch_req = dir_v[g] || start_v[g];
		assign u_if.stop       = stop_v[g];
		assign u_if.sil        = sil_v[g];
		assign u_if.rep_set    = rset_v[g];
		assign u_if.rep_clr    = rclr_v[g];
		assign u_if.phrase     = phrase_in;
		assign u_if.sil_code   = wbyte;
		assign ready_v[g]      = u_if.ready;
		assign busy_v[g]       = u_if.busy_n;
		assign rep_v[g]        = u_if.rep;
		cpd_chan u_ch (
			.core_clk  (core_clk),
			.rst_n     (rst_n),
			.bus       (u_if.chan),
			.tick      (tick),
			.direct_phrase_launch_cmd_done (direct_phrase_launch_cmd_done[g]),
			.launch    (launch[g]),
			.halt      (halt[g]),
			.out_phrase(launch_phrase[g])
		);
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	AST_SELECT_ONE_CHAN: assert property (
		second && op_pend == OP_SELECT && ready_v[pend_byte[1:0]]
		|-> sel_v == chan_hot && $onehot(sel_v))
		else $error("select hit wrong channel");
	AST_ZERO_MASK_IGNORED: assert property (
		ex1 && m_new == 4'h0
		|-> start_v == 4'h0 && stop_v == 4'h0 && rset_v == 4'h0 && rclr_v == 4'h0)
		else $error("zero mask acted");
	AST_ZERO_MASK_NO_EFFECT: assert property (
		ex1 && m_new == 4'h0 && direct_phrase_launch_cmd_done == 4'h0 && !tick
		|=> launch == 4'h0 && halt == 4'h0)
		else $error("zero mask changed a channel");
	AST_STOP_ANY_READY: assert property (
		ex1 && op_new == OP_STOP
		|=> halt == $past(m_new) && (channel_busy_n & $past(m_new)) == $past(m_new))
		else $error("stop not taken");
	AST_START_GATED: assert property (
		ex1 && op_new == OP_START && (m_new & ready_v & ~launch & channel_busy_n) == m_new
		|=> (launch & $past(m_new)) == $past(m_new))
		else $error("start did not launch");
	AST_REPSET_GATED: assert property (
		ex1 && op_new == OP_REPSET
		|=> rep_v == ($past(rep_v) | ($past(m_new) & $past(ready_v))))
		else $error("repeat set on wrong channels");
	AST_REPCLR_ANY: assert property (
		ex1 && op_new == OP_REPCLR && stop_v == 4'h0
		|=> (rep_v & $past(m_new)) == 4'h0)
		else $error("repeat not cancelled");
	AST_TWO_BYTE_PAIR: assert property (
		first && two_byte |=> pend_valid && pend_byte == $past(wbyte))
		else $error("first byte not held");
	AST_UNMAPPED_ERR: assert property (
		acc && !hit_cmd && !hit_stat |-> pslverr)
		else $error("unmapped access not flagged");
endmodule : cpd_top

// ### src/cpd_pkg.sv
// Purpose: Shared constants and types of the playback command decoder
// Assumes: 100 MHz core clock
// Notes:   Opcodes sit in the upper nibble of the first byte
package cpd_pkg;
	localparam int CH_N     = 4;
	localparam int PHRASE_W = 10;
	localparam int SIL_W    = 8;
	localparam int ADDR_W   = 8;
	localparam int DATA_W   = 32;

	localparam logic [3:0] OP_SELECT = 4'h3;
	localparam logic [3:0] OP_DIRECT = 4'h4;
	localparam logic [3:0] OP_START  = 4'h5;
	localparam logic [3:0] OP_STOP   = 4'h6;
	localparam logic [3:0] OP_SIL    = 4'h7;
	localparam logic [3:0] OP_REPSET = 4'h8;
	localparam logic [3:0] OP_REPCLR = 4'h9;

	localparam logic [ADDR_W-1:0] ADDR_CMD    = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;

	localparam int ST_READY_LSB = 0;
	localparam int ST_BUSYN_LSB = 4;
	localparam int ST_REP_LSB   = 8;
	localparam int ST_PEND_BIT  = 12;

	localparam logic [DATA_W-1:0] RDATA_ZERO = 32'h0000_0000;
	localparam logic [SIL_W:0]    SIL_ONE    = 9'h001;

	localparam int SIL_UNIT_MS  = 4;
	localparam int CLK_KHZ      = 100_000;
	localparam int SIL_TICK_CYC = SIL_UNIT_MS * CLK_KHZ;

	typedef logic [PHRASE_W-1:0] cpd_phrase_t;
	typedef logic [CH_N-1:0]     cpd_mask_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_DIRECT_PHRASE_LAUNCH_CMD = 3'b010,
		ST_SIL  = 3'b100
	} cpd_state_t;
endpackage : cpd_pkg

// ### src/cpd_chan_if.sv
// Purpose: Command strobes to one channel and its status back
// Assumes: Strobes are single-cycle
// Notes:   One instance per channel
`timescale 1ns/1ns
interface cpd_chan_if;
	import cpd_pkg::*;
	logic                 sel;
	logic                 launch_req;
	logic                 stop;
	logic                 sil;
	logic                 rep_set;
	logic                 rep_clr;
	cpd_phrase_t          phrase;
	logic [SIL_W-1:0]     sil_code;
	logic                 ready;
	logic                 busy_n;
	logic                 rep;
	modport dec  (output sel, launch_req, stop, sil, rep_set, rep_clr, phrase, sil_code,
		input ready, busy_n, rep);
	modport chan (input sel, launch_req, stop, sil, rep_set, rep_clr, phrase, sil_code,
		output ready, busy_n, rep);
endinterface : cpd_chan_if

// ### src/cpd_tick.sv
// Purpose: Silence time base, one pulse per silence unit
// Assumes: Single clock domain
// Notes:   Free running
`timescale 1ns/1ns
module cpd_tick #(
	parameter int CYCLES = cpd_pkg::SIL_TICK_CYC
) (
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic rst_n,
	// Enable pulse
	output logic      tick
);
	import cpd_pkg::*;
	logic [31:0] cnt;
	wire         wrap = (cnt == 32'(CYCLES - 1));

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt  <= 32'h0000_0000;
			tick <= 1'b0;
		end else begin
			cnt  <= wrap ? 32'h0000_0000 : cnt + 32'h0000_0001;
			tick <= wrap;
		end
	end
endmodule : cpd_tick

// ### src/cpd_chan.sv
// Purpose: Playback sequencer of one channel
// Assumes: Decoder gates ready-bound commands
// Notes:   One queued phrase or silence behind the running one
`timescale 1ns/1ns
module cpd_chan (
	// Clock and reset
	input  wire logic         core_clk,
	input  wire logic         rst_n,
	// Commands
	cpd_chan_if.chan          bus,
	// Engine side
	input  wire logic         tick,
	input  wire logic         direct_phrase_launch_cmd_done,
	output logic              launch,
	output logic              halt,
	output cpd_pkg::cpd_phrase_t out_phrase
);
	import cpd_pkg::*;
	cpd_state_t        state;
	cpd_phrase_t       phrase_latch;
	logic              rep;
	logic              q_valid;
	logic              q_sil;
	logic [SIL_W-1:0]  q_code;
	logic [SIL_W:0]    sil_cnt;

	wire cpd_phrase_t phrase_use = bus.sel ? bus.phrase : phrase_latch;
	wire direct_phrase_launch_cmd_end  = (state == ST_DIRECT_PHRASE_LAUNCH_CMD) && direct_phrase_launch_cmd_done;
	wire sil_end   = (state == ST_SIL) && tick && (sil_cnt == SIL_ONE);
	wire relaunch  = direct_phrase_launch_cmd_end && rep && !bus.rep_clr;
	wire ending    = sil_end || (direct_phrase_launch_cmd_end && !relaunch);
	wire new_req   = bus.launch_req || bus.sil;
	wire from_q    = ending && q_valid;
	wire free      = (state == ST_IDLE) || (ending && !q_valid);
	wire go        = from_q || (free && new_req);
	wire go_sil    = from_q ? q_sil : bus.sil;
	wire [SIL_W-1:0] go_code = from_q ? q_code : bus.sil_code;

	assign bus.ready  = !q_valid && !rep;
	assign bus.busy_n = (state == ST_IDLE);
	assign bus.rep    = rep;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state        <= ST_IDLE;
			phrase_latch <= '0;
			out_phrase   <= '0;
			rep          <= 1'b0;
			q_valid      <= 1'b0;
			q_sil        <= 1'b0;
			q_code       <= '0;
			sil_cnt      <= '0;
			launch       <= 1'b0;
			halt         <= 1'b0;
		end else begin
			launch <= 1'b0;
			halt   <= 1'b0;
			if (bus.sel)
				phrase_latch <= bus.phrase;
			if (bus.stop) begin
				state   <= ST_IDLE;
				rep     <= 1'b0;
				q_valid <= 1'b0;
				halt    <= 1'b1;
			end else begin
				if (bus.rep_clr)
					rep <= 1'b0;
				else if (bus.rep_set)
					rep <= 1'b1;
				if (relaunch) begin
					launch     <= 1'b1;
				end else if (go && go_sil) begin
					state   <= ST_SIL;
					sil_cnt <= {1'b0, go_code} + SIL_ONE;
				end else if (go) begin
					state      <= ST_DIRECT_PHRASE_LAUNCH_CMD;
					launch     <= 1'b1;
					out_phrase <= phrase_use;
				end else if (ending) begin
					state <= ST_IDLE;
				end else if (state == ST_SIL && tick) begin
					sil_cnt <= sil_cnt - SIL_ONE;
				end
				if (from_q) begin
					q_valid <= 1'b0;
				end else if (!free && new_req) begin
					q_valid <= 1'b1;
					q_sil   <= bus.sil;
					q_code  <= bus.sil_code;
				end
			end
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	AST_LATCH_NO_LAUNCH: assert property (
		bus.sel && !bus.launch_req && !direct_phrase_launch_cmd_done && !bus.stop
		|=> phrase_latch == $past(bus.phrase) && !launch)
		else $error("select launched or did not latch");
	AST_DIRECT_LAUNCH: assert property (
		state == ST_IDLE && bus.launch_req && !bus.stop
		|=> launch && state == ST_DIRECT_PHRASE_LAUNCH_CMD && out_phrase == $past(phrase_use))
		else $error("launch missing from idle");
	AST_STOP_RELEASES: assert property (
		bus.stop |=> bus.busy_n && bus.ready && halt && !launch)
		else $error("stop left channel busy");
	AST_SIL_LOAD: assert property (
		state == ST_IDLE && bus.sil && !bus.stop
		|=> state == ST_SIL && sil_cnt == {1'b0, $past(bus.sil_code)} + SIL_ONE)
		else $error("silence count wrong");
	AST_SIL_NO_REPEAT: assert property (
		sil_end && !q_valid && !bus.stop && !bus.launch_req && !bus.sil
		|=> state == ST_IDLE && !launch)
		else $error("silence replayed");
	AST_REPEAT: assert property (
		direct_phrase_launch_cmd_end && rep && !bus.stop && !bus.rep_clr
		|=> launch && state == ST_DIRECT_PHRASE_LAUNCH_CMD && out_phrase == $past(out_phrase))
		else $error("repeat not relaunched");
	AST_REPCLR_READY: assert property (
		bus.rep_clr && !bus.stop && !q_valid && !new_req ##1 !bus.rep_set
		|-> bus.ready)
		else $error("ready low after repeat release");
endmodule : cpd_chan

// ### sim/cpd_engine_model.sv
// Purpose: Playback engine stand-in, answers each launch with a done pulse
// Assumes: A delay of zero means the phrase never ends
// Notes:   Halt drops the running phrase at once
`timescale 1ns/1ns
module cpd_engine_model (
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	// Engine side
	input  wire logic [3:0] launch,
	input  wire logic [3:0] halt,
	input  wire logic [7:0] dly,
	output logic      [3:0] direct_phrase_launch_cmd_done
);
	logic [7:0] cnt [4];

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt       <= '{default: 8'h00};
			direct_phrase_launch_cmd_done <= 4'h0;
		end else begin
			for (int c = 0; c < 4; c++) begin
				direct_phrase_launch_cmd_done[c] <= (cnt[c] == 8'h01) && !halt[c];
				if (halt[c])
					cnt[c] <= 8'h00;
				else if (launch[c])
					cnt[c] <= dly;
				else if (cnt[c] != 8'h00)
					cnt[c] <= cnt[c] - 8'h01;
			end
		end
	end
endmodule : cpd_engine_model

// ### sim/cpd_top_tb_top.sv
// Purpose: Self-checking bench of the playback command decoder
// Assumes: Zero-wait APB slave, short silence unit
// Notes:   Launch and halt pulses are counted per channel
`timescale 1ns/1ns
module cpd_top_tb_top;
	import cpd_pkg::*;
	localparam int TK = 5;
	logic                   core_clk;
	logic                   rst_n;
	logic                   psel;
	logic                   penable;
	logic                   pwrite;
	logic [ADDR_W-1:0]      paddr;
	logic [DATA_W-1:0]      pwdata;
	logic [DATA_W-1:0]      prdata;
	logic                   pready;
	logic                   pslverr;
	logic [CH_N-1:0]        command_ready_line;
	logic [CH_N-1:0]        channel_busy_n;
	logic [CH_N-1:0]        direct_phrase_launch_cmd_done;
	logic [CH_N-1:0]        launch;
	logic [CH_N-1:0]        halt;
	cpd_phrase_t [CH_N-1:0] launch_phrase;
	logic [7:0]             dly;
	logic [31:0]            lcnt [4];
	logic [31:0]            hcnt [4];
	cpd_phrase_t            lph [4];
	int                     fail_count;
	int                     compares;

	cpd_top #(.TICK_CYCLES(TK)) cpd_top_i (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .command_ready_line(command_ready_line),
		.channel_busy_n(channel_busy_n), .direct_phrase_launch_cmd_done(direct_phrase_launch_cmd_done), .launch(launch), .halt(halt),
		.launch_phrase(launch_phrase));
	cpd_engine_model cpd_engine_model_i (.core_clk(core_clk), .rst_n(rst_n), .launch(launch),
		.halt(halt), .dly(dly), .direct_phrase_launch_cmd_done(direct_phrase_launch_cmd_done));

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		for (int c = 0; c < 4; c++) begin
			if (launch[c] === 1'b1) begin
				lcnt[c] = lcnt[c] + 1;
				lph[c]  = launch_phrase[c];
			end
			if (halt[c] === 1'b1)
				hcnt[c] = hcnt[c] + 1;
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic er);
		int n;
		n = 0;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		while (pready !== 1'b1 && n < 50) begin
			n++;
			@(posedge core_clk);
		end
		if (n >= 50)
			fail_count++;
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		// Idle edge so the next call never reassigns in this time step
		@(posedge core_clk);
	endtask : apb

	task automatic wr(input logic [7:0] b);
		logic [31:0] rd;
		logic        er;
		apb(1'b1, ADDR_CMD, {24'h00_0000, b}, rd, er);
	endtask : wr

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask : cyc

	task automatic wait_idle;
		int n;
		n = 0;
		while ((channel_busy_n !== 4'hF || command_ready_line !== 4'hF) && n < 3000) begin
			n++;
			@(posedge core_clk);
		end
		chk({31'h0000_0000, n < 3000}, 32'h0000_0001);
	endtask : wait_idle

	function automatic logic [31:0] tot;
		return lcnt[0] + lcnt[1] + lcnt[2] + lcnt[3];
	endfunction : tot

	task automatic test_done;
		$display("fail_count=%0d compares=%0d", fail_count, compares);
		if (fail_count == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : test_done

	initial begin
		repeat (30000) @(posedge core_clk);
		fail_count++;
		test_done();
	end

	initial begin
		cpd_phrase_t ph [4];
		logic [31:0] rd;
		logic [31:0] base;
		logic        er;
		logic [3:0]  m;
		int          n;
		int          code;
		rst_n = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		dly = 8'h06;
		fail_count = 0;
		compares = 0;
		lcnt = '{default: 32'h0000_0000};
		hcnt = '{default: 32'h0000_0000};
		void'($urandom(32761));
		cyc(20);
		rst_n <= 1'b1;
		@(posedge core_clk);
		apb(1'b0, ADDR_STATUS, 32'h0000_0000, rd, er);
		chk(rd, 32'h0000_00FF);
		apb(1'b0, 8'h08, 32'h0000_0000, rd, er);
		chk({31'h0000_0000, er}, 32'h0000_0001);
		// Direct direct_phrase_launch_cmd on every channel, both phrase ends among them
		for (int c = 0; c < 4; c++) begin
			ph[c] = (c == 0) ? 10'h3FF : (c == 1) ? 10'h000 : cpd_phrase_t'($urandom_range(1023));
			base = tot();
			wr({OP_DIRECT, ph[c][9:8], c[1:0]});
			wr(ph[c][7:0]);
			cyc(2);
			chk(tot(), base + 1);
			chk(lph[c], ph[c]);
		end
		wait_idle();
		// Host latches phrases while ready, then starts by mask
		// select while ready
		for (int c = 0; c < 4; c++) begin
			ph[c] = cpd_phrase_t'($urandom_range(1023));
			wr({OP_SELECT, ph[c][9:8], c[1:0]});
			wr(ph[c][7:0]);
		end
		base = tot();
		wr(8'h50);
		wr(8'h60);
		wr(8'h80);
		wr(8'h90);
		wr(8'h70);
		wr(8'h10);
		wr(8'hA1);
		cyc(2);
		chk(tot(), base);
		apb(1'b0, ADDR_STATUS, 32'h0000_0000, rd, er);
		chk(rd, 32'h0000_00FF);
		m = 4'(($urandom_range(6) * 2) + 3);
		wr({OP_START, m});
		cyc(2);
		for (int c = 0; c < 4; c++) begin
			chk(lcnt[c], 32'h0000_0001 + 32'(m[c]));
			if (m[c])
				chk(lph[c], ph[c]);
		end
		wait_idle();
		// Stop while the channel queue holds ready low
		dly = 8'h00;
		wr(8'h42);
		wr(8'h21);
		cyc(2);
		wr(8'h42);
		wr(8'h22);
		cyc(2);
		chk({31'h0000_0000, command_ready_line[2]}, 32'h0000_0000);
		base = hcnt[2];
		wr({OP_STOP, 4'h4});
		cyc(2);
		chk(hcnt[2], base + 1);
		chk({24'h00_0000, channel_busy_n, command_ready_line}, 32'h0000_00FF);
		dly = 8'h06;
		// Silence length counted on the busy line, repeat set while it runs
		// silence while ready
		code = $urandom_range(9, 4);
		base = tot();
		wr({OP_SIL, 4'h1});
		wr(8'(code));
		wr({OP_REPSET, 4'h1});
		// Repeat-set write above spans three cycles
		n = 3;
		@(posedge core_clk);
		while (channel_busy_n[0] !== 1'b1 && n < 500) begin
			n++;
			@(posedge core_clk);
		end
		chk({31'h0000_0000, n >= code * TK - 1 && n <= (code + 1) * TK + 2}, 32'h0000_0001);
		cyc(2);
		chk(tot(), base);
		// Repeat cleared in idle, then set during playback
		wr({OP_REPCLR, 4'h1});
		chk({31'h0000_0000, command_ready_line[0]}, 32'h0000_0001);
		base = lcnt[0];
		wr(8'h44);
		wr(8'h2C);
		wr({OP_REPSET, 4'h1});
		n = 0;
		while (lcnt[0] < base + 3 && n < 200) begin
			n++;
			@(posedge core_clk);
		end
		chk(lcnt[0], base + 3);
		chk(lph[0], 10'h12C);
		chk({31'h0000_0000, command_ready_line[0]}, 32'h0000_0000);
		wr({OP_REPCLR, 4'h1});
		cyc(2);
		chk({31'h0000_0000, command_ready_line[0]}, 32'h0000_0001);
		base = lcnt[0];
		wait_idle();
		chk(lcnt[0], base);
		test_done();
	end
endmodule : cpd_top_tb_top
